// ==== hw/ccs_core_state.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccs_core_state #(
	parameter int unsigned CORE_DIV    = ccs_pkg::CORE_DIV,
	parameter int unsigned CONV_DIV    = ccs_pkg::CONV_DIV,
	parameter int unsigned RESET_DELAY = ccs_pkg::RESET_DELAY
) (
	input  wire logic                         clock_in,
	input  wire logic                         rst_n_in,
	input  wire logic                         ext_reset_n_in,
	input  wire logic                         por_in,
	input  wire logic                         wdg_timeout_in,
	input  wire logic                         op_valid_in,
	input  wire ccs_pkg::ccs_op_s             op_in,
	input  wire logic [11:0]                  vector_in,
	input  wire logic [ccs_pkg::BANK_W-1:0]   bank_in,
	input  wire ccs_pkg::ccs_dsp_s            dsp_in,
	output logic      [7:0]                   dsp_rdata_out,
	output logic                              dsp_hit_out,
	output logic      [11:0]                  pc_out,
	output logic      [ccs_pkg::BANK_W-1:0]   prog_bank_out,
	output logic                              core_tick_out,
	output logic                              conv_tick_out,
	output logic      [2:0]                   ctx_out,
	output logic                              carry_out,
	output logic                              zero_out,
	output logic      [7:0]                   acc_out,
	output logic                              stack_empty_out,
	output logic                              core_rst_out,
	output logic                              osc_restart_out
);
	logic [3:0]  core_cnt;
	logic [3:0]  conv_cnt;
	logic [11:0] pc;
	logic [7:0]  accumulator;
	logic [7:0]  pointer_reg_first;
	logic [7:0]  pointer_reg_second;
	logic [7:0]  short_direct_first;
	logic [7:0]  short_direct_second;
	logic [2:0]  carry_bank;
	logic [2:0]  zero_bank;
	ccs_pkg::ccs_ctx_e ctx;
	ccs_pkg::ccs_ctx_e nmi_prev;
	ccs_pkg::ccs_ctx_e next_ctx;
	logic [11:0] next_pc;
	logic        push;
	logic        pop;
	logic [11:0] stack_top;
	logic        stack_empty;
	logic        next_carry;
	logic        next_zero;
	logic [7:0]  next_acc;
	logic        acc_load;
	logic        flag_load;

	if (CORE_DIV < 2 || CORE_DIV > 16 || CONV_DIV < 2 || CONV_DIV > 16) begin : bad_div
		$error("Clock dividers must lie between 2 and 16.");
	end

	ccs_reset_seq #(
		.DELAY(RESET_DELAY)
	) u_reset (
		.clock_in       (clock_in),
		.rst_n_in       (rst_n_in),
		.ext_reset_n_in (ext_reset_n_in),
		.por_in         (por_in),
		.wdg_timeout_in (wdg_timeout_in),
		.core_rst_out   (core_rst_out),
		.osc_restart_out(osc_restart_out)
	);

	ccs_ret_stack #(
		.DEPTH(ccs_pkg::STACK_DEPTH),
		.WIDTH(ccs_pkg::PC_W)
	) u_stack (
		.clock_in    (clock_in),
		.rst_n_in    (rst_n_in),
		.clear_in    (core_rst_out),
		.push_in     (push),
		.pop_in      (pop),
		.push_data_in(pc),
		.top_out     (stack_top),
		.empty_out   (stack_empty)
	);

	wire core_wrap = (core_cnt == 4'(CORE_DIV - 1));
	wire conv_wrap = (conv_cnt == 4'(CONV_DIV - 1));
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			core_cnt      <= 4'h0;
			conv_cnt      <= 4'h0;
			core_tick_out <= 1'b0;
			conv_tick_out <= 1'b0;
		end else begin
			core_cnt      <= core_wrap ? 4'h0 : core_cnt + 4'h1;
			conv_cnt      <= conv_wrap ? 4'h0 : conv_cnt + 4'h1;
			core_tick_out <= core_wrap;
			conv_tick_out <= conv_wrap;
		end
	end

	// The core stays halted for as long as internal reset is held.
	wire take = core_tick_out & op_valid_in & ~core_rst_out;
	wire [11:0] pc_inc = pc + 12'h001;
	wire [11:0] pc_rel = pc + {{4{op_in.operand[7]}}, op_in.operand};
	wire carry_now = |(carry_bank & ctx);
	wire zero_now  = |(zero_bank & ctx);
	wire [8:0] sum9  = {1'b0, accumulator} + {1'b0, op_in.operand};
	wire [8:0] diff9 = {1'b0, accumulator} - {1'b0, op_in.operand};
	wire [7:0] and8  = accumulator & op_in.operand;
	wire [7:0] or8   = accumulator | op_in.operand;

	always_comb begin
		next_pc  = pc;
		next_ctx = ctx;
		push     = 1'b0;
		pop      = 1'b0;
		if (take) begin
			case (op_in.pc_op)
				ccs_pkg::PC_NEXT:   next_pc = pc_inc;
				ccs_pkg::PC_JUMP:   next_pc = op_in.target;
				ccs_pkg::PC_CALL: begin
					next_pc = op_in.target;
					push    = 1'b1;
				end
				ccs_pkg::PC_BRANCH: next_pc = pc_rel;
				ccs_pkg::PC_IRQ: begin
					next_pc  = vector_in;
					push     = 1'b1;
					next_ctx = ccs_pkg::CTX_IRQ;
				end
				ccs_pkg::PC_NMI: begin
					next_pc  = vector_in;
					push     = 1'b1;
					next_ctx = ccs_pkg::CTX_NMI;
				end
				ccs_pkg::PC_RET, ccs_pkg::PC_INTERRUPT_RETURN_INSTR: begin
					pop     = 1'b1;
					next_pc = stack_empty ? pc_inc : stack_top;
					if (op_in.pc_op == ccs_pkg::PC_INTERRUPT_RETURN_INSTR) begin
						next_ctx = (ctx == ccs_pkg::CTX_NMI) ? nmi_prev : ccs_pkg::CTX_NORMAL;
					end
				end
				default:            next_pc = pc;
			endcase
		end
	end

	always_comb begin
		next_carry = carry_now;
		next_zero  = zero_now;
		next_acc   = accumulator;
		acc_load   = 1'b0;
		flag_load  = take;
		case (op_in.alu_op)
			ccs_pkg::ALU_ADD: begin
				{next_carry, next_acc} = sum9;
				acc_load = 1'b1;
			end
			ccs_pkg::ALU_SUB: begin
				{next_carry, next_acc} = diff9;
				acc_load = 1'b1;
			end
			ccs_pkg::ALU_AND: begin
				next_acc = and8;
				acc_load = 1'b1;
			end
			ccs_pkg::ALU_OR: begin
				next_acc = or8;
				acc_load = 1'b1;
			end
			ccs_pkg::ALU_BTEST: next_carry = op_in.operand[op_in.bit_sel];
			ccs_pkg::ALU_RLC: begin
				{next_carry, next_acc} = {accumulator, carry_now};
				acc_load = 1'b1;
			end
			default:            flag_load = 1'b0;
		endcase
		if (acc_load) begin
			next_zero = (next_acc == 8'h00);
		end
	end

	wire hit_acc = (dsp_in.addr == ccs_pkg::ADDR_ACC);
	wire hit_xf  = (dsp_in.addr == ccs_pkg::ADDR_PTR_FIRST);
	wire hit_xs  = (dsp_in.addr == ccs_pkg::ADDR_PTR_SECOND);
	wire hit_sf  = (dsp_in.addr == ccs_pkg::ADDR_SD_FIRST);
	wire hit_ss  = (dsp_in.addr == ccs_pkg::ADDR_SD_SECOND);
	wire hit_any = hit_acc | hit_xf | hit_xs | hit_sf | hit_ss;
	wire [7:0] rd_mux = hit_acc ? accumulator :
		hit_xf ? pointer_reg_first :
		hit_xs ? pointer_reg_second :
		hit_sf ? short_direct_first :
		hit_ss ? short_direct_second : 8'h00;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pointer_reg_first   <= ccs_pkg::DATA_RESET;
			pointer_reg_second  <= ccs_pkg::DATA_RESET;
			short_direct_first  <= ccs_pkg::DATA_RESET;
			short_direct_second <= ccs_pkg::DATA_RESET;
		end else if (dsp_in.wr) begin
			if (hit_xf) pointer_reg_first <= dsp_in.wdata;
			if (hit_xs) pointer_reg_second <= dsp_in.wdata;
			if (hit_sf) short_direct_first <= dsp_in.wdata;
			if (hit_ss) short_direct_second <= dsp_in.wdata;
		end
	end

	// An ALU result beats a data-space store to the accumulator in the same cycle.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			accumulator <= ccs_pkg::DATA_RESET;
		end else if (take && acc_load) begin
			accumulator <= next_acc;
		end else if (dsp_in.wr && hit_acc) begin
			accumulator <= dsp_in.wdata;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dsp_rdata_out <= 8'h00;
			dsp_hit_out   <= 1'b0;
		end else begin
			dsp_rdata_out <= dsp_in.rd ? rd_mux : 8'h00;
			dsp_hit_out   <= dsp_in.rd & hit_any;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pc       <= ccs_pkg::RESET_VECTOR;
			ctx      <= ccs_pkg::CTX_NMI;
			nmi_prev <= ccs_pkg::CTX_NORMAL;
		end else if (core_rst_out) begin
			pc       <= ccs_pkg::RESET_VECTOR;
			ctx      <= ccs_pkg::CTX_NMI;
			nmi_prev <= ccs_pkg::CTX_NORMAL;
		end else begin
			pc  <= next_pc;
			ctx <= next_ctx;
			if (take && op_in.pc_op == ccs_pkg::PC_NMI) begin
				nmi_prev <= ctx;
			end
		end
	end

	wire [2:0] bank_sel        = ctx;
	wire [2:0] carry_upd       = (carry_bank & ~bank_sel) | (bank_sel & {3{next_carry}});
	wire [2:0] zero_upd        = (zero_bank & ~bank_sel) | (bank_sel & {3{next_zero}});
	wire [2:0] next_carry_bank = flag_load ? carry_upd : carry_bank;
	wire [2:0] next_zero_bank  = flag_load ? zero_upd : zero_bank;
	// The flag outputs follow the context that is active after this edge, not the one before it.
	wire [2:0] ctx_after       = core_rst_out ? ccs_pkg::CTX_NMI : next_ctx;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			carry_bank <= 3'h0;
			zero_bank  <= 3'h0;
		end else begin
			carry_bank <= next_carry_bank;
			zero_bank  <= next_zero_bank;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prog_bank_out <= '0;
			carry_out     <= 1'b0;
			zero_out      <= 1'b0;
		end else begin
			prog_bank_out <= bank_in;
			carry_out     <= |(next_carry_bank & ctx_after);
			zero_out      <= |(next_zero_bank & ctx_after);
		end
	end

	assign pc_out          = pc;
	assign ctx_out         = ctx;
	assign acc_out         = accumulator;
	assign stack_empty_out = stack_empty;

	core_tick_gap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		core_tick_out |=> !core_tick_out [*8])
		else $error("Core ticks closer than the divider allows.");
	pc_step_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(take && op_in.pc_op == ccs_pkg::PC_NEXT) |=> pc == $past(pc) + 12'h001)
		else $error("Counter did not advance by one.");
	branch_wrap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(take && op_in.pc_op == ccs_pkg::PC_BRANCH) |=> (pc == $past(pc_rel) && $stable(prog_bank_out)))
		else $error("Branch target or bank wrong.");
	reset_entry_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$fell(core_rst_out) |-> (pc == ccs_pkg::RESET_VECTOR && ctx == ccs_pkg::CTX_NMI && stack_empty))
		else $error("Core left reset without vector, context or empty stack.");
	flags_kept_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(ctx != $past(ctx) && !$past(flag_load)) |-> ($stable(carry_bank) && $stable(zero_bank)))
		else $error("Context switch altered stored flags.");
	zero_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(take && op_in.alu_op == ccs_pkg::ALU_ADD) |=> ((|(zero_bank & $past(ctx))) == (accumulator == 8'h00)))
		else $error("Zero flag does not match the result.");
	acc_store_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(dsp_in.wr && hit_acc && !(take && acc_load)) |=> accumulator == $past(dsp_in.wdata))
		else $error("Accumulator not written through data space.");
	interrupt_return_instr_restore_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(take && op_in.pc_op == ccs_pkg::PC_INTERRUPT_RETURN_INSTR && ctx == ccs_pkg::CTX_IRQ) |=> ctx == ccs_pkg::CTX_NORMAL)
		else $error("Interrupt return did not restore the normal pair.");
endmodule : ccs_core_state
`default_nettype wire

// ==== hw/ccs_pkg.sv ====
// Notes on behaviour
// - Eight-bit accumulator for all ALU work except bit test, also data-space location FFh.
// - Two pointer registers at data-space 80h and 81h, any direct mode.
// - Two short-direct registers at data-space 82h and 83h.
// - Twelve-bit program counter holds next program address, reaching 4096 bytes.
// - Program space beyond 4096 bytes is reached through a bank register.
// - Counter loads jump, call, branch, vector or popped value, holds on the hold op, else adds one.
// - Three carry/zero pairs: normal, maskable and non-maskable context.
// - Interrupt entry switches pair, return from non-maskable restores previous pair, from maskable selects normal, nothing cleared.
// - Only the active context's flag pair can be read or changed.
// - Carry follows carry or borrow, bit test copies bit, rotate uses carry.
// - Zero flag set for zero result of arithmetic or logic, else cleared.
// - After reset the core runs in non-maskable context with its flags.
// - Six-level twelve-bit return stack; push shifts down, counter enters level one.
// - Return pops level one into counter and shifts remaining levels up.
// - Pushing a full stack drops the deepest entry; depth stays six.
// - Return on empty stack leaves it unchanged and continues sequentially.
// - Core runs at internal clock over 13, converter and watchdog over 12.
// - Instructions take two, four or five machine cycles of one tick each; the core takes every op on a single tick.
// - Reset from external pin, power-on or watchdog; held while pin low.
// - Reset in run or wait halts core, ports to pulled-up inputs, oscillator restarts on pin or power-on reset, not on watchdog.
// - Reset in stop starts oscillator, ports pulled-up inputs, init after delay.
// - Internal reset released 2048 internal clocks after the external release.
// - Reset clears the stack and loads the counter with vector 0FFEh.
package ccs_pkg;
	localparam int unsigned PC_W        = 12;
	localparam int unsigned BANK_W      = 4;
	localparam int unsigned CORE_DIV    = 13;
	localparam int unsigned CONV_DIV    = 12;
	localparam int unsigned RESET_DELAY = 2048;
	localparam int unsigned STACK_DEPTH = 6;
	localparam logic [7:0] ADDR_PTR_FIRST  = 8'h80;
	localparam logic [7:0] ADDR_PTR_SECOND = 8'h81;
	localparam logic [7:0] ADDR_SD_FIRST   = 8'h82;
	localparam logic [7:0] ADDR_SD_SECOND  = 8'h83;
	localparam logic [7:0] ADDR_ACC        = 8'hff;
	localparam logic [7:0] DATA_RESET      = 8'h00;
	localparam logic [11:0] RESET_VECTOR   = 12'hffe;

	typedef enum logic [2:0] {
		CTX_NORMAL = 3'b001,
		CTX_IRQ    = 3'b010,
		CTX_NMI    = 3'b100
	} ccs_ctx_e;

	typedef enum logic [3:0] {
		PC_HOLD   = 4'h0,
		PC_NEXT   = 4'h1,
		PC_JUMP   = 4'h2,
		PC_CALL   = 4'h3,
		PC_BRANCH = 4'h4,
		PC_IRQ    = 4'h5,
		PC_NMI    = 4'h6,
		PC_RET    = 4'h7,
		PC_INTERRUPT_RETURN_INSTR   = 4'h8
	} ccs_pc_op_e;

	typedef enum logic [2:0] {
		ALU_NONE  = 3'h0,
		ALU_ADD   = 3'h1,
		ALU_SUB   = 3'h2,
		ALU_AND   = 3'h3,
		ALU_OR    = 3'h4,
		ALU_BTEST = 3'h5,
		ALU_RLC   = 3'h6
	} ccs_alu_op_e;

	typedef struct packed {
		ccs_pc_op_e  pc_op;
		ccs_alu_op_e alu_op;
		logic [11:0] target;
		logic [7:0]  operand;
		logic [2:0]  bit_sel;
	} ccs_op_s;

	typedef struct packed {
		logic [7:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} ccs_dsp_s;
endpackage : ccs_pkg

// ==== hw/ccs_ret_stack.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccs_ret_stack #(
	parameter int unsigned DEPTH = ccs_pkg::STACK_DEPTH,
	parameter int unsigned WIDTH = ccs_pkg::PC_W
) (
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	input  wire logic             clear_in,
	input  wire logic             push_in,
	input  wire logic             pop_in,
	input  wire logic [WIDTH-1:0] push_data_in,
	output logic      [WIDTH-1:0] top_out,
	output logic                  empty_out
);
	localparam int unsigned FW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] level [DEPTH];
	logic [FW-1:0]    fill;

	if (DEPTH < 2) begin : bad_depth
		$error("Stack depth must be at least two.");
	end

	assign top_out   = level[0];

	for (genvar i = 0; i < DEPTH; i++) begin : lvl
		always_ff @(posedge clock_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				level[i] <= '0;
			end else if (clear_in) begin
				level[i] <= '0;
			end else if (push_in) begin
				if (i == 0) begin
					level[i] <= push_data_in;
				end else begin
					level[i] <= level[(i == 0) ? 0 : i-1];
				end
			end else if (pop_in && !empty_out) begin
				level[i] <= (i == DEPTH-1) ? '0 : level[(i == DEPTH-1) ? i : i+1];
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fill <= '0;
		end else if (clear_in) begin
			fill <= '0;
		end else if (push_in && fill != FW'(DEPTH)) begin
			fill <= fill + 1'b1;
		end else if (pop_in && !push_in && !empty_out) begin
			fill <= fill - 1'b1;
		end
	end

	// The empty flag has its own flop so that it leaves the core registered.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			empty_out <= 1'b1;
		end else if (clear_in) begin
			empty_out <= 1'b1;
		end else if (push_in) begin
			empty_out <= 1'b0;
		end else if (pop_in && fill == FW'(1)) begin
			empty_out <= 1'b1;
		end
	end

	full_push_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(fill == FW'(DEPTH) && push_in && !clear_in) |=> (fill == FW'(DEPTH) && top_out == $past(push_data_in)))
		else $error("Full stack did not stay at maximum depth.");
	empty_pop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(empty_out && pop_in && !push_in && !clear_in) |=> (empty_out && $stable(top_out)))
		else $error("Pop on empty stack changed it.");
endmodule : ccs_ret_stack
`default_nettype wire

// ==== hw/ccs_reset_seq.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccs_reset_seq #(
	parameter int unsigned DELAY = ccs_pkg::RESET_DELAY
) (
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	input  wire logic ext_reset_n_in,
	input  wire logic por_in,
	input  wire logic wdg_timeout_in,
	output logic      core_rst_out,
	output logic      osc_restart_out
);
	localparam int unsigned CW = $clog2(DELAY + 1);
	logic [1:0]    sync0;
	logic [1:0]    sync1;
	logic [1:0]    sync2;
	logic [1:0]    held;
	logic          held_q;
	logic [CW-1:0] cnt;
	wire           held_any = |held;
	wire           rst_req  = held_any | wdg_timeout_in;

	if (DELAY < 2) begin : bad_delay
		$error("Reset delay must be at least two cycles.");
	end

	// A pin level is believed only once the second and third stages agree.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync0 <= 2'h3;
			sync1 <= 2'h3;
			sync2 <= 2'h3;
			held  <= 2'h3;
		end else begin
			sync0 <= {por_in, ~ext_reset_n_in};
			sync1 <= sync0;
			sync2 <= sync1;
			for (int k = 0; k < 2; k++) begin
				if (sync1[k] == sync2[k]) begin
					held[k] <= sync2[k];
				end
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt          <= '0;
			core_rst_out <= 1'b1;
		end else if (rst_req) begin
			cnt          <= '0;
			core_rst_out <= 1'b1;
		end else if (core_rst_out && cnt == CW'(DELAY - 1)) begin
			core_rst_out <= 1'b0;
		end else if (core_rst_out) begin
			cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			held_q          <= 1'b1;
			osc_restart_out <= 1'b0;
		end else begin
			held_q          <= held_any;
			osc_restart_out <= held_any & ~held_q;
		end
	end

	release_delay_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$fell(core_rst_out) |-> ($past(cnt) == CW'(DELAY - 1) && !$past(rst_req)))
		else $error("Internal reset released before the delay expired.");
	reset_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		rst_req |=> core_rst_out [*2])
		else $error("Reset request did not hold internal reset.");
endmodule : ccs_reset_seq
`default_nettype wire

// ==== dv/ccs_prog_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccs_prog_mem_model #(
	parameter logic [11:0] IRQ_VEC = 12'h400,
	parameter logic [11:0] NMI_VEC = 12'h7f0
) (
	input  wire ccs_pkg::ccs_op_s op_in,
	output logic [11:0]           vector_out
);
	// Vector words live in program memory; only the fetched address reaches the core.
	// vector for interrupts
	assign vector_out = (op_in.pc_op == ccs_pkg::PC_NMI) ? NMI_VEC : IRQ_VEC;
endmodule : ccs_prog_mem_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
	localparam int unsigned DLY = 16;
	logic              clock_in = 1'b0;
	logic              rst_n_in, ext_reset_n_in, por_in, wdg_timeout_in, op_valid_in;
	ccs_pkg::ccs_op_s  op_in;
	ccs_pkg::ccs_dsp_s dsp_in;
	logic [11:0]       vector_in, pc_out;
	logic [3:0]        bank_in, prog_bank_out;
	logic [7:0]        dsp_rdata_out, acc_out;
	logic [2:0]        ctx_out;
	logic              dsp_hit_out, core_tick_out, conv_tick_out, carry_out, zero_out;
	logic              stack_empty_out, core_rst_out, osc_restart_out, osc_seen;
	int                n_fail = 0, samples_checked = 0, cycles = 0, n, k;

	ccs_core_state #(.RESET_DELAY(DLY)) uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.ext_reset_n_in(ext_reset_n_in), .por_in(por_in), .wdg_timeout_in(wdg_timeout_in),
		.op_valid_in(op_valid_in), .op_in(op_in), .vector_in(vector_in), .bank_in(bank_in),
		.dsp_in(dsp_in), .dsp_rdata_out(dsp_rdata_out), .dsp_hit_out(dsp_hit_out), .pc_out(pc_out),
		.prog_bank_out(prog_bank_out), .core_tick_out(core_tick_out), .conv_tick_out(conv_tick_out),
		.ctx_out(ctx_out), .carry_out(carry_out), .zero_out(zero_out), .acc_out(acc_out),
		.stack_empty_out(stack_empty_out), .core_rst_out(core_rst_out), .osc_restart_out(osc_restart_out));
	ccs_prog_mem_model u_mem (.op_in(op_in), .vector_out(vector_in));

	always #2 clock_in = ~clock_in;

	// A hang ends the run through the same report as a normal finish.
	always @(posedge clock_in) begin
		cycles++;
		if (osc_restart_out === 1'b1) osc_seen <= 1'b1;
		if (cycles == 20000) begin
			n_fail++;
			$display("Error t=%0t timeout", $time);
			close_out();
		end
	end

	task close_out;
		$display("checks %0d errors %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	// Holds the request until a machine-cycle tick takes it, then drops it.
	task do_op(input ccs_pkg::ccs_pc_op_e p, input ccs_pkg::ccs_alu_op_e a, input logic [11:0] t,
		input logic [7:0] d, input logic [2:0] b);
		int i;
		@(posedge clock_in);
		op_in <= '{p, a, t, d, b};
		op_valid_in <= 1'b1;
		i = 0;
		do begin @(negedge clock_in); i++; end while (!(core_tick_out === 1'b1 && core_rst_out === 1'b0) && i < 40);
		@(posedge clock_in);
		op_valid_in <= 1'b0;
		@(negedge clock_in);
	endtask : do_op

	task dsp_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		dsp_in <= '{a, 1'b0, 1'b1, d};
		@(posedge clock_in);
		dsp_in <= '0;
	endtask : dsp_wr

	task dsp_rd(input logic [7:0] a, input logic [7:0] e, input logic h);
		@(posedge clock_in);
		dsp_in <= '{a, 1'b1, 1'b0, 8'h00};
		@(posedge clock_in);
		@(negedge clock_in);
		`CHK(dsp_rdata_out, e);
		`CHK(dsp_hit_out, h);
		@(posedge clock_in);
		dsp_in <= '0;
	endtask : dsp_rd

	task gap(input logic conv, output int g);
		int i;
		i = 0;
		do begin @(negedge clock_in); i++; end while ((conv ? conv_tick_out : core_tick_out) !== 1'b1 && i < 40);
		g = 0;
		do begin @(negedge clock_in); g++; end while ((conv ? conv_tick_out : core_tick_out) !== 1'b1 && g < 40);
	endtask : gap

	// Source 0 is the pin, 1 power-on, 2 a watchdog pulse.
	task rst_src(input int s);
		@(negedge clock_in);
		osc_seen = 1'b0;
		@(posedge clock_in);
		case (s)
			0: ext_reset_n_in <= 1'b0;
			1: por_in <= 1'b1;
			default: wdg_timeout_in <= 1'b1;
		endcase
		repeat (s == 2 ? 1 : 8) @(posedge clock_in);
		ext_reset_n_in <= 1'b1;
		por_in <= 1'b0;
		wdg_timeout_in <= 1'b0;
		repeat (3) @(negedge clock_in);
		`CHK(core_rst_out, 1'b1);
		`CHK(pc_out, ccs_pkg::RESET_VECTOR);
		`CHK(stack_empty_out, 1'b1);
		`CHK(ctx_out, 3'b100);
		n = 0;
		while (core_rst_out !== 1'b0 && n < 100) begin @(negedge clock_in); n++; end
		`CHK(1'(n >= DLY - 4 && n <= DLY + 6), 1'b1);
		`CHK(osc_seen, 1'(s != 2));
	endtask : rst_src

	initial begin
		rst_n_in = 1'b0; ext_reset_n_in = 1'b1; por_in = 1'b0; wdg_timeout_in = 1'b0;
		op_valid_in = 1'b0; op_in = '0; dsp_in = '0; bank_in = 4'h0; osc_seen = 1'b0;
		repeat (16) @(posedge clock_in);
		rst_n_in <= 1'b1;
		n = 0;
		while (core_rst_out !== 1'b0 && n < 200) begin @(negedge clock_in); n++; end
		`CHK(pc_out, ccs_pkg::RESET_VECTOR);
		`CHK(ctx_out, 3'b100);
		gap(1'b0, n);
		`CHK(n, 13);
		gap(1'b1, n);
		`CHK(n, 12);
		for (k = 0; k < 5; k++) dsp_wr(k == 4 ? 8'hff : 8'h80 + 8'(k), {k[3:0] + 4'h1, 4'ha});
		for (k = 0; k < 5; k++) dsp_rd(k == 4 ? 8'hff : 8'h80 + 8'(k), {k[3:0] + 4'h1, 4'ha}, 1'b1);
		`CHK(acc_out, 8'h5a);
		dsp_rd(8'h84, 8'h00, 1'b0);
		dsp_wr(8'hff, 8'hff);
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_ADD, 12'h000, 8'h01, 3'd0);
		`CHK({acc_out, carry_out, zero_out}, {8'h00, 2'b11});
		`CHK(pc_out, 12'hfff);
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK(pc_out, 12'h000);
		do_op(ccs_pkg::PC_INTERRUPT_RETURN_INSTR, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK({ctx_out, pc_out, stack_empty_out}, {3'b001, 12'h001, 1'b1});
		`CHK({carry_out, zero_out}, 2'b00);
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_SUB, 12'h000, 8'h01, 3'd0);
		`CHK({acc_out, carry_out, zero_out}, {8'hff, 2'b10});
		do_op(ccs_pkg::PC_IRQ, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK({ctx_out, pc_out, carry_out, zero_out}, {3'b010, 12'h400, 2'b00});
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_AND, 12'h000, 8'h00, 3'd0);
		`CHK({acc_out, carry_out, zero_out}, {8'h00, 2'b01});
		do_op(ccs_pkg::PC_INTERRUPT_RETURN_INSTR, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK({ctx_out, pc_out, carry_out, zero_out}, {3'b001, 12'h002, 2'b10});
		do_op(ccs_pkg::PC_NMI, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK({ctx_out, pc_out, carry_out, zero_out}, {3'b100, 12'h7f0, 2'b11});
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_BTEST, 12'h000, 8'h04, 3'd2);
		`CHK({carry_out, zero_out}, 2'b11);
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_BTEST, 12'h000, 8'h04, 3'd0);
		`CHK({carry_out, zero_out}, 2'b01);
		dsp_wr(8'hff, 8'h81);
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_RLC, 12'h000, 8'h00, 3'd0);
		`CHK({acc_out, carry_out, zero_out}, {8'h02, 2'b10});
		do_op(ccs_pkg::PC_NEXT, ccs_pkg::ALU_OR, 12'h000, 8'h00, 3'd0);
		`CHK({acc_out, carry_out, zero_out}, {8'h02, 2'b10});
		do_op(ccs_pkg::PC_INTERRUPT_RETURN_INSTR, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK({ctx_out, pc_out}, {3'b001, 12'h002});
		do_op(ccs_pkg::PC_HOLD, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK(pc_out, 12'h002);
		@(posedge clock_in);
		bank_in <= 4'h5;
		do_op(ccs_pkg::PC_JUMP, ccs_pkg::ALU_NONE, 12'hffe, 8'h00, 3'd0);
		`CHK(pc_out, 12'hffe);
		do_op(ccs_pkg::PC_BRANCH, ccs_pkg::ALU_NONE, 12'h000, 8'h04, 3'd0);
		`CHK({pc_out, prog_bank_out}, {12'h002, 4'h5});
		do_op(ccs_pkg::PC_BRANCH, ccs_pkg::ALU_NONE, 12'h000, 8'hfc, 3'd0);
		`CHK({pc_out, prog_bank_out}, {12'hffe, 4'h5});
		do_op(ccs_pkg::PC_JUMP, ccs_pkg::ALU_NONE, 12'h100, 8'h00, 3'd0);
		for (k = 1; k <= 7; k++) begin
			do_op(ccs_pkg::PC_CALL, ccs_pkg::ALU_NONE, 12'((k + 1) * 256), 8'h00, 3'd0);
			`CHK(pc_out, 12'((k + 1) * 256));
		end
		for (k = 7; k >= 2; k--) begin
			do_op(ccs_pkg::PC_RET, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
			`CHK(pc_out, 12'(k * 256));
		end
		`CHK(stack_empty_out, 1'b1);
		do_op(ccs_pkg::PC_RET, ccs_pkg::ALU_NONE, 12'h000, 8'h00, 3'd0);
		`CHK({pc_out, stack_empty_out}, {12'h201, 1'b1});
		for (k = 0; k < 3; k++) begin
			do_op(ccs_pkg::PC_CALL, ccs_pkg::ALU_NONE, 12'h123, 8'h00, 3'd0);
			rst_src(k);
		end
		close_out();
	end
endmodule : testbench
`default_nettype wire
